// ==== rsc_pkg.sv ====
// Package with register offsets, codes, states and timing constants for registration control.
`default_nettype none
package rsc_pkg;
  // Register offsets in the numbered status register space.
  localparam logic [7:0] REG_TIMEOUT_OFS = 8'h0d;
  localparam logic [7:0] REG_FAIL_OFS = 8'h38;
  localparam logic [7:0] REG_NETSTAT_OFS = 8'h39;
  localparam logic [7:0] REG_PHASE_OFS = 8'h3e;
  localparam logic [7:0] REG_CAUSE_OFS = 8'h3f;
  localparam logic [7:0] REG_AVAIL_OFS = 8'h65;
  localparam logic [7:0] REG_RSSI_OFS = 8'h66;
  localparam logic [7:0] REG_PROGRESS_OFS = 8'h7e;
  // Values after reset.
  localparam logic [7:0] TIMEOUT_RST = 8'h3c;
  localparam logic [7:0] ZERO_RST = 8'h00;
  // Network status bit positions.
  localparam int NS_REGISTERED = 0;
  localparam int NS_CONNECTED = 2;
  localparam int NS_CONN_FAIL = 3;
  localparam int NS_CONN_LINKED = 4;
  localparam int NS_POWER_ON = 5;
  localparam int NS_IN_RANGE = 7;
  // Registration progress codes.
  localparam logic [7:0] PROG_INACTIVE = 8'h00;
  localparam logic [7:0] PROG_COMPLETE = 8'h05;
  // Local failure codes.
  localparam logic [7:0] FAIL_HOME_TIMEOUT = 8'hfa;
  localparam logic [7:0] FAIL_LINK_PARAM = 8'hfb;
  localparam logic [7:0] FAIL_LINK_VERSION = 8'hfc;
  localparam logic [7:0] FAIL_NO_ACCESS = 8'hfe;
  localparam logic [7:0] FAIL_NOT_REGISTERED = 8'hff;
  localparam logic [7:0] FAIL_REFUSE_MAX = 8'h07;
  // Timing: terminal-ready low time and one second, in cycles at 200 MHz.
  localparam int CLK_HZ = 200_000_000;
  localparam int TR_LOW_MS = 15;
  localparam int TR_LOW_CYC = (CLK_HZ / 1000) * TR_LOW_MS;
  localparam int SEC_CYC = CLK_HZ;
  // Escape option of the terminal-ready line.
  typedef enum logic [1:0] {
    RSC_IGNORE_TR = 2'd0,
    RSC_TR_ESCAPE = 2'd1,
    RSC_TR_ESCAPE_HANGUP = 2'd2
  } rsc_tr_mode_t;
  // Commands decoded by the host command parser.
  typedef enum logic [3:0] {
    RSC_CMD_NONE = 4'h0,
    RSC_CMD_DEREGISTER = 4'h1,
    RSC_CMD_MANUAL_REG = 4'h2,
    RSC_CMD_CONN_LINKED = 4'h3,
    RSC_CMD_CONN_LINKED_OFF = 4'h4,
    RSC_CMD_POWER_ON = 4'h5,
    RSC_CMD_POWER_ON_OFF = 4'h6,
    RSC_CMD_SET_TIMEOUT = 4'h7,
    RSC_CMD_QUERY = 4'h8,
    RSC_CMD_ONLINE = 4'h9,
    RSC_CMD_LINE_START = 4'ha,
    RSC_CMD_SAVE = 4'hb,
    RSC_CMD_RESTART = 4'hc,
    RSC_CMD_DIAL = 4'hd,
    RSC_CMD_HANGUP = 4'he
  } rsc_cmd_t;
  // Command from the host side.
  typedef struct packed {
    logic valid;
    rsc_cmd_t cmd;
    logic [7:0] addr;
    logic [7:0] data;
  } rsc_cmd_req_t;
  // Event and status inputs from the protocol engine.
  typedef struct packed {
    logic in_range;
    logic available;
    logic [7:0] rssi;
    logic [7:0] progress;
    logic reg_fail;
    logic [7:0] fail_code;
    logic reg_lost;
    logic connected;
    logic conn_fail;
    logic [7:0] fail_phase;
    logic [7:0] fail_cause;
  } rsc_net_t;
  // Registration engine states, Gray along idle-attempt-registered.
  typedef enum logic [1:0] {
    RSC_ST_IDLE = 2'b00,
    RSC_ST_ATTEMPT = 2'b01,
    RSC_ST_REGISTERED = 2'b11,
    RSC_ST_DEREG = 2'b10
  } rsc_state_t;
endpackage : rsc_pkg
`default_nettype wire

// ==== rsc_sync.sv ====
// Two-flop synchroniser for a pin input.
`default_nettype none
module rsc_sync (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic din,
  output logic dout
);
  logic meta_r;
  // The first stage feeds only the second stage.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      meta_r <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule : rsc_sync
`default_nettype wire

// ==== rsc_tick.sv ====
// Seconds tick generator used by the registration timer.
`default_nettype none
module rsc_tick #(
  parameter int SEC_CYCLES = rsc_pkg::SEC_CYC
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic restart,
  output logic tick
);
  logic [31:0] cnt_r;
  // Restart aligns the first second to the start of an attempt.
  always_ff @(posedge sys_clk) begin
    if (sys_rst || restart) begin
      cnt_r <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (cnt_r == 32'(SEC_CYCLES - 1)) begin
      cnt_r <= 32'h0000_0000;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h0000_0001;
      tick <= 1'b0;
    end
  end
endmodule : rsc_tick
`default_nettype wire

// ==== rsc_ctrl.sv ====
// Registration status and control block of the packet-data modem.
`default_nettype none
module rsc_ctrl #(
  parameter int SEC_CYCLES = rsc_pkg::SEC_CYC,
  parameter int TR_LOW_CYCLES = rsc_pkg::TR_LOW_CYC,
  parameter bit FLOW_CTRL_CFG = 1'b1
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic terminal_ready_pin,
  input wire rsc_pkg::rsc_tr_mode_t tr_mode,
  input wire rsc_pkg::rsc_cmd_req_t cmd_req,
  output logic cmd_ready,
  output logic cmd_done,
  output logic cmd_error,
  output logic [7:0] rd_data,
  input wire rsc_pkg::rsc_net_t net,
  output logic reg_request,
  output logic dereg_request,
  output logic hangup_request,
  output logic online_mode,
  output logic autobaud_enable,
  output logic flow_ctrl_enable,
  output logic save_request,
  output logic [7:0] saved_netstat
);
  // Pin path and escape detection.
  logic tr_sync;
  logic [31:0] tr_low_cnt_r;
  logic tr_escape;
  logic tick;
  logic tick_restart;
  // Engine state and the timer register.
  rsc_pkg::rsc_state_t state_r;
  logic [7:0] timeout_r;
  // Status register copies.
  logic [7:0] fail_r;
  logic [7:0] phase_r;
  logic [7:0] cause_r;
  logic [7:0] avail_r;
  logic [7:0] rssi_r;
  logic [7:0] progress_r;
  // Network status bits.
  logic bit_registered_r;
  logic bit_linked_r;
  logic bit_power_on_r;
  logic bit_connected_r;
  logic bit_conn_fail_r;
  logic bit_in_range_r;
  logic power_on_suspended_r;
  logic manual_block_r;
  logic boot_pending_r;
  // Whole seconds in this attempt.
  logic [7:0] secs_r;
  // Shared strobes.
  logic cmd_take;
  logic attempt_start;
  logic attempt_expired;
  logic [7:0] netstat;

  // Terminal-ready pin crosses into the clock domain first.
  rsc_sync u_tr_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .din(terminal_ready_pin),
    .dout(tr_sync)
  );

  // Seconds base for the registration timer.
  // The timer resolves whole seconds only.
  rsc_tick #(
    .SEC_CYCLES(SEC_CYCLES)
  ) u_tick (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .restart(tick_restart),
    .tick(tick)
  );

  // Count low time; escape only once the line stayed low long enough.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tr_low_cnt_r <= 32'h0000_0000;
    end else begin
      // Saturates, so a long low never escapes twice.
      if (tr_sync) begin
        tr_low_cnt_r <= 32'h0000_0000;
      end else if (tr_low_cnt_r != 32'hffff_ffff) begin
        tr_low_cnt_r <= tr_low_cnt_r + 32'h0000_0001;
      end
    end
  end
  // A short glitch below the minimum low time is not an escape.
  assign tr_escape = !tr_sync && (tr_low_cnt_r == 32'(TR_LOW_CYCLES - 1)) &&
                     (tr_mode != rsc_pkg::RSC_IGNORE_TR);

  // Online mode: entered by an accepted dial, online or line-start command.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      online_mode <= 1'b0;
      hangup_request <= 1'b0;
    end else begin
      hangup_request <= 1'b0;
      if (tr_escape) begin
        online_mode <= 1'b0;
        hangup_request <= (tr_mode == rsc_pkg::RSC_TR_ESCAPE_HANGUP);
      end else if (cmd_take && (cmd_req.cmd == rsc_pkg::RSC_CMD_ONLINE ||
                   cmd_req.cmd == rsc_pkg::RSC_CMD_LINE_START ||
                   cmd_req.cmd == rsc_pkg::RSC_CMD_DIAL)) begin
        online_mode <= 1'b1;
      end
    end
  end
  // Both follow online mode at once.
  assign autobaud_enable = !online_mode;
  assign flow_ctrl_enable = online_mode && FLOW_CTRL_CFG;

  // Commands are refused in online mode and while manual registration runs.
  // Refused, not queued: the host retries.
  assign cmd_ready = !online_mode && !manual_block_r;
  assign cmd_take = cmd_req.valid && cmd_ready;

  // Network status value assembled from its bits.
  // Bits 1 and 6 have no source.
  always_comb begin
    netstat = 8'h00;
    netstat[rsc_pkg::NS_REGISTERED] = bit_registered_r;
    netstat[rsc_pkg::NS_CONNECTED] = bit_connected_r;
    netstat[rsc_pkg::NS_CONN_FAIL] = bit_conn_fail_r;
    netstat[rsc_pkg::NS_CONN_LINKED] = bit_linked_r;
    netstat[rsc_pkg::NS_POWER_ON] = bit_power_on_r;
    netstat[rsc_pkg::NS_IN_RANGE] = bit_in_range_r;
  end

  // Query answers and command completion are registered.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_data <= 8'h00;
      cmd_done <= 1'b0;
    end else begin
      // Manual registration is done as its block lifts, or at once when already registered.
      cmd_done <= (cmd_take && cmd_req.cmd != rsc_pkg::RSC_CMD_MANUAL_REG) ||
                  (cmd_take && bit_registered_r) ||
                  (manual_block_r && state_r == rsc_pkg::RSC_ST_ATTEMPT &&
                   (net.progress == rsc_pkg::PROG_COMPLETE || attempt_expired));
      // Unmapped offsets answer zero.
      if (cmd_take && cmd_req.cmd == rsc_pkg::RSC_CMD_QUERY) begin
        case (cmd_req.addr)
          rsc_pkg::REG_TIMEOUT_OFS: rd_data <= timeout_r;
          rsc_pkg::REG_FAIL_OFS: rd_data <= fail_r;
          rsc_pkg::REG_NETSTAT_OFS: rd_data <= netstat;
          rsc_pkg::REG_PHASE_OFS: rd_data <= phase_r;
          rsc_pkg::REG_CAUSE_OFS: rd_data <= cause_r;
          rsc_pkg::REG_AVAIL_OFS: rd_data <= avail_r;
          rsc_pkg::REG_RSSI_OFS: rd_data <= rssi_r;
          rsc_pkg::REG_PROGRESS_OFS: rd_data <= progress_r;
          default: rd_data <= 8'h00;
        endcase
      end
    end
  end

  // Timer register and enable bits written by commands.
  // Saving only hands a copy out.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      timeout_r <= rsc_pkg::TIMEOUT_RST;
      bit_linked_r <= 1'b0;
      bit_power_on_r <= 1'b0;
      save_request <= 1'b0;
      saved_netstat <= 8'h00;
    end else begin
      save_request <= 1'b0;
      if (cmd_take) begin
        case (cmd_req.cmd)
          rsc_pkg::RSC_CMD_SET_TIMEOUT: timeout_r <= cmd_req.data;
          rsc_pkg::RSC_CMD_CONN_LINKED: bit_linked_r <= 1'b1;
          rsc_pkg::RSC_CMD_CONN_LINKED_OFF: bit_linked_r <= 1'b0;
          rsc_pkg::RSC_CMD_POWER_ON: bit_power_on_r <= 1'b1;
          rsc_pkg::RSC_CMD_POWER_ON_OFF: bit_power_on_r <= 1'b0;
          rsc_pkg::RSC_CMD_SAVE: begin
            save_request <= 1'b1;
            saved_netstat <= netstat;
          end
          default: ;
        endcase
      end
    end
  end

  // Status mirrors of the protocol engine; failure codes pass verbatim.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fail_r <= rsc_pkg::ZERO_RST;
      phase_r <= rsc_pkg::ZERO_RST;
      cause_r <= rsc_pkg::ZERO_RST;
      avail_r <= rsc_pkg::ZERO_RST;
      rssi_r <= rsc_pkg::ZERO_RST;
      progress_r <= rsc_pkg::PROG_INACTIVE;
      bit_in_range_r <= 1'b0;
      bit_connected_r <= 1'b0;
      bit_conn_fail_r <= 1'b0;
    end else begin
      bit_in_range_r <= net.in_range;
      avail_r <= {7'h00, net.available};
      rssi_r <= net.rssi;
      progress_r <= net.progress;
      bit_connected_r <= net.connected && !net.conn_fail;
      bit_conn_fail_r <= net.conn_fail;
      // Phase and cause move only with the pulse.
      if (net.conn_fail) begin
        phase_r <= net.fail_phase;
        cause_r <= net.fail_cause;
      end
      // A timeout outranks a refusal.
      if (attempt_expired) begin
        fail_r <= rsc_pkg::FAIL_HOME_TIMEOUT;
      end else if (cmd_take && cmd_req.cmd == rsc_pkg::RSC_CMD_DEREGISTER &&
                   !bit_registered_r) begin
        fail_r <= rsc_pkg::FAIL_NOT_REGISTERED;
      end else if (net.reg_fail) begin
        fail_r <= net.fail_code;
      end
    end
  end

  // Attempt starts: manual, power-up, loss with zero timer, or linked dial.
  assign attempt_start = (state_r != rsc_pkg::RSC_ST_ATTEMPT) && !bit_registered_r && (
      (cmd_take && cmd_req.cmd == rsc_pkg::RSC_CMD_MANUAL_REG) ||
      (boot_pending_r && net.available && bit_power_on_r && !power_on_suspended_r) ||
      (bit_power_on_r && !power_on_suspended_r && timeout_r == 8'h00 &&
       net.available && state_r == rsc_pkg::RSC_ST_IDLE && !boot_pending_r) ||
      (bit_linked_r && cmd_take && cmd_req.cmd == rsc_pkg::RSC_CMD_DIAL));
  // The first second is then a full one.
  assign tick_restart = attempt_start;
  // A zero timer never expires, so the attempt retries until success.
  assign attempt_expired = (state_r == rsc_pkg::RSC_ST_ATTEMPT) && (timeout_r != 8'h00) &&
                           tick && (secs_r + 8'h01 >= timeout_r);

  // Registration engine.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r <= rsc_pkg::RSC_ST_IDLE;
      secs_r <= 8'h00;
      bit_registered_r <= 1'b0;
      manual_block_r <= 1'b0;
      power_on_suspended_r <= 1'b0;
      boot_pending_r <= 1'b1;
      reg_request <= 1'b0;
      dereg_request <= 1'b0;
      cmd_error <= 1'b0;
    end else begin
      reg_request <= 1'b0;
      dereg_request <= 1'b0;
      cmd_error <= 1'b0;
      // Restart lifts the hold and rearms power-on.
      if (cmd_take && cmd_req.cmd == rsc_pkg::RSC_CMD_RESTART) begin
        power_on_suspended_r <= 1'b0;
        boot_pending_r <= 1'b1;
      end
      case (state_r)
        // Only idle starts an attempt.
        rsc_pkg::RSC_ST_IDLE: begin
          if (attempt_start) begin
            state_r <= rsc_pkg::RSC_ST_ATTEMPT;
            secs_r <= 8'h00;
            reg_request <= 1'b1;
            boot_pending_r <= 1'b0;
            manual_block_r <= cmd_take && cmd_req.cmd == rsc_pkg::RSC_CMD_MANUAL_REG;
          end
        end
        rsc_pkg::RSC_ST_ATTEMPT: begin
          if (tick) begin
            secs_r <= secs_r + 8'h01;
          end
          // Completion wins over expiry.
          if (net.progress == rsc_pkg::PROG_COMPLETE) begin
            state_r <= rsc_pkg::RSC_ST_REGISTERED;
            bit_registered_r <= 1'b1;
            manual_block_r <= 1'b0;
          end else if (attempt_expired) begin
            state_r <= rsc_pkg::RSC_ST_IDLE;
            manual_block_r <= 1'b0;
            cmd_error <= 1'b1;
          end else if (net.reg_fail && timeout_r == 8'h00) begin
            reg_request <= 1'b1;
          end
        end
        rsc_pkg::RSC_ST_REGISTERED: begin
          // A loss outranks a host command.
          if (net.reg_lost) begin
            state_r <= rsc_pkg::RSC_ST_IDLE;
            bit_registered_r <= 1'b0;
          end else if (cmd_take && (cmd_req.cmd == rsc_pkg::RSC_CMD_DEREGISTER ||
                       (bit_linked_r && cmd_req.cmd == rsc_pkg::RSC_CMD_HANGUP))) begin
            state_r <= rsc_pkg::RSC_ST_DEREG;
            dereg_request <= 1'b1;
          end
        end
        // The bit drops as the request leaves.
        rsc_pkg::RSC_ST_DEREG: begin
          state_r <= rsc_pkg::RSC_ST_IDLE;
          bit_registered_r <= 1'b0;
        end
        default: state_r <= rsc_pkg::RSC_ST_IDLE;
      endcase
      // Deregister works in any state and stops power-on retries.
      if (cmd_take && cmd_req.cmd == rsc_pkg::RSC_CMD_DEREGISTER) begin
        power_on_suspended_r <= 1'b1;
        if (state_r == rsc_pkg::RSC_ST_ATTEMPT) begin
          state_r <= rsc_pkg::RSC_ST_IDLE;
          dereg_request <= 1'b1;
        end
      end
    end
  end
endmodule : rsc_ctrl
`default_nettype wire

// ==== rsc_ctrl_sva.sv ====
// Checker with concurrent assertions on the registration control ports.
`default_nettype none
module rsc_ctrl_sva #(
  parameter int SEC_CYCLES = 10,
  parameter int TR_LOW_CYCLES = 4,
  parameter bit FLOW_CTRL_CFG = 1'b1
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic terminal_ready_pin,
  input wire rsc_pkg::rsc_tr_mode_t tr_mode,
  input wire rsc_pkg::rsc_cmd_req_t cmd_req,
  input wire logic cmd_ready,
  input wire logic cmd_done,
  input wire logic cmd_error,
  input wire logic [7:0] rd_data,
  input wire rsc_pkg::rsc_net_t net,
  input wire logic reg_request,
  input wire logic dereg_request,
  input wire logic hangup_request,
  input wire logic online_mode,
  input wire logic autobaud_enable,
  input wire logic flow_ctrl_enable,
  input wire logic save_request,
  input wire logic [7:0] saved_netstat
);
  logic acc;
  logic qry;
  int low_cnt_r;
  // Accepted command and accepted query, as seen at the sampling edge.
  assign acc = cmd_req.valid && cmd_ready;
  assign qry = acc && cmd_req.cmd == rsc_pkg::RSC_CMD_QUERY;
  // Counts cycles the pin has been low, so an early escape can be caught.
  always_ff @(posedge sys_clk) begin
    low_cnt_r <= terminal_ready_pin ? 0 : low_cnt_r + 1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  cmd_done_next_a: assert property (acc && cmd_req.cmd != rsc_pkg::RSC_CMD_MANUAL_REG &&
    cmd_req.cmd != rsc_pkg::RSC_CMD_NONE |=> cmd_done) else $error("command not completed");
  manual_blocks_a: assert property (acc && cmd_req.cmd == rsc_pkg::RSC_CMD_MANUAL_REG
    |=> !cmd_ready) else $error("commands accepted during registration");
  online_refuse_a: assert property (online_mode |-> !cmd_ready)
    else $error("command accepted while online");
  online_side_a: assert property (autobaud_enable == !online_mode &&
    flow_ctrl_enable == (online_mode && FLOW_CTRL_CFG)) else $error("online side effects wrong");
  ignore_online_a: assert property (online_mode && tr_mode == rsc_pkg::RSC_IGNORE_TR
    |=> online_mode) else $error("left online mode while ignoring the pin");
  escape_time_a: assert property ($fell(online_mode) |-> low_cnt_r >= TR_LOW_CYCLES &&
    tr_mode != rsc_pkg::RSC_IGNORE_TR) else $error("escape too early or not enabled");
  hangup_mode_a: assert property (hangup_request |->
    tr_mode == rsc_pkg::RSC_TR_ESCAPE_HANGUP) else $error("hang-up without hang-up option");
  rd_hold_a: assert property (!qry |=> $stable(rd_data))
    else $error("read data changed without a query");
  unmapped_zero_a: assert property (qry && cmd_req.addr == 8'h01 |=> rd_data == 8'h00)
    else $error("unmapped offset did not read zero");
  in_range_a: assert property (qry && cmd_req.addr == rsc_pkg::REG_NETSTAT_OFS &&
    net.in_range && $past(net.in_range) && $past(net.in_range, 2) |=> rd_data[7])
    else $error("in-range bit missing");
  manual_cov: cover property (acc && cmd_req.cmd == rsc_pkg::RSC_CMD_MANUAL_REG);
  escape_cov: cover property ($fell(online_mode));
  error_cov: cover property (cmd_error);
endmodule : rsc_ctrl_sva
bind rsc_ctrl rsc_ctrl_sva #(.SEC_CYCLES(SEC_CYCLES), .TR_LOW_CYCLES(TR_LOW_CYCLES),
  .FLOW_CTRL_CFG(FLOW_CTRL_CFG)) rsc_ctrl_sva_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .terminal_ready_pin(terminal_ready_pin), .tr_mode(tr_mode), .cmd_req(cmd_req),
  .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_error(cmd_error), .rd_data(rd_data),
  .net(net), .reg_request(reg_request), .dereg_request(dereg_request),
  .hangup_request(hangup_request), .online_mode(online_mode),
  .autobaud_enable(autobaud_enable), .flow_ctrl_enable(flow_ctrl_enable),
  .save_request(save_request), .saved_netstat(saved_netstat));
`default_nettype wire

// ==== rsc_net_model.sv ====
// Behavioural model of the packet network registration engine.
`default_nettype none
module rsc_net_model (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic reg_request,
  input wire logic dereg_request,
  input wire logic [1:0] mode,
  input wire logic [7:0] refuse_code,
  input wire logic conn_up,
  input wire logic conn_pulse,
  input wire logic [7:0] phase,
  input wire logic [7:0] cause,
  output var rsc_pkg::rsc_net_t net
);
  logic [7:0] prog_r;
  logic [2:0] wait_r;
  logic busy_r;
  logic fail_r;
  // Mode 0 completes, mode 1 stalls, mode 2 refuses after a short wait.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prog_r <= 8'h00;
      busy_r <= 1'b0;
      fail_r <= 1'b0;
      wait_r <= 3'h0;
    end else begin
      fail_r <= 1'b0;
      if (dereg_request) begin
        prog_r <= 8'h00;
        busy_r <= 1'b0;
      end else if (reg_request) begin
        prog_r <= 8'h01;
        busy_r <= 1'b1;
        wait_r <= 3'h0;
      end else if (busy_r && mode == 2'd0) begin
        prog_r <= prog_r + 8'h01;
        busy_r <= (prog_r != 8'h04);
      end else if (busy_r && mode == 2'd2) begin
        wait_r <= wait_r + 3'h1;
        if (wait_r == 3'h3) begin
          fail_r <= 1'b1;
          busy_r <= 1'b0;
          prog_r <= 8'h00;
        end
      end
    end
  end
  // Codes are only valid with their pulse, so they show garbage otherwise.
  assign net = '{in_range: 1'b1, available: 1'b1, rssi: 8'hb0, progress: prog_r,
    reg_fail: fail_r, fail_code: fail_r ? refuse_code : ~refuse_code, reg_lost: 1'b0,
    connected: conn_up, conn_fail: conn_pulse, fail_phase: conn_pulse ? phase : ~phase,
    fail_cause: conn_pulse ? cause : ~cause};
endmodule : rsc_net_model
`default_nettype wire

// ==== testbench.sv ====
// Self-checking testbench for the registration control block.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SEC = 10;
  localparam int TRL = 4;
  logic sys_clk = 1'b0, sys_rst = 1'b1, pin = 1'b1;
  rsc_pkg::rsc_tr_mode_t tr_mode = rsc_pkg::RSC_IGNORE_TR;
  rsc_pkg::rsc_cmd_req_t cmd_req = '0;
  rsc_pkg::rsc_net_t net;
  logic cmd_ready, cmd_done, cmd_error, reg_request, dereg_request, hangup_request;
  logic online_mode, autobaud_enable, flow_ctrl_enable, save_request;
  logic [7:0] rd_data, saved_netstat, refuse_code = 8'h00, phase = 8'h00, cause = 8'h00;
  logic [1:0] mode = 2'd0;
  logic conn_up = 1'b0, conn_pulse = 1'b0;
  int miscompares = 0, tests_run = 0, reg_cnt = 0, hang_cnt = 0;
  rsc_ctrl #(.SEC_CYCLES(SEC), .TR_LOW_CYCLES(TRL), .FLOW_CTRL_CFG(1'b1)) rsc_ctrl_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .terminal_ready_pin(pin), .tr_mode(tr_mode),
    .cmd_req(cmd_req), .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_error(cmd_error),
    .rd_data(rd_data), .net(net), .reg_request(reg_request), .dereg_request(dereg_request),
    .hangup_request(hangup_request), .online_mode(online_mode),
    .autobaud_enable(autobaud_enable), .flow_ctrl_enable(flow_ctrl_enable),
    .save_request(save_request), .saved_netstat(saved_netstat));
  rsc_net_model rsc_net_model_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .reg_request(reg_request), .dereg_request(dereg_request), .mode(mode),
    .refuse_code(refuse_code), .conn_up(conn_up), .conn_pulse(conn_pulse),
    .phase(phase), .cause(cause), .net(net));
  // Free-running clock and pulse counters for request outputs.
  initial forever #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (reg_request === 1'b1) reg_cnt++;
    if (hangup_request === 1'b1) hang_cnt++;
  end
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  task automatic chk(logic [7:0] seen, logic [7:0] exp, string msg);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : chk
  // Holds a command until an edge takes it; returns just after that edge.
  task automatic cmd(rsc_pkg::rsc_cmd_t c, logic [7:0] a, logic [7:0] d);
    int n = 0;
    @(posedge sys_clk);
    cmd_req <= '{1'b1, c, a, d};
    @(posedge sys_clk);
    while (cmd_ready !== 1'b1) begin
      n++;
      if (n > 40) begin
        miscompares++;
        finish_test();
      end
      @(posedge sys_clk);
    end
    cmd_req.valid <= 1'b0;
    #1;
  endtask : cmd
  task automatic q(logic [7:0] a, logic [7:0] mask, logic [7:0] exp, string m);
    cmd(rsc_pkg::RSC_CMD_QUERY, a, 8'h00);
    chk({7'h0, cmd_done}, 8'h01, m);
    chk(rd_data & mask, exp, m);
  endtask : q
  // Bounded wait on completion, or on error when on_err is set; a hang ends the run.
  task automatic wait_sig(int n, bit on_err, output int cyc);
    cyc = 0;
    while ((on_err ? cmd_error : cmd_done) !== 1'b1) begin
      if (cyc == n) begin
        miscompares++;
        finish_test();
      end
      @(posedge sys_clk);
      #1;
      cyc++;
    end
  endtask : wait_sig
  task automatic t_basics();
    chk({7'h0, cmd_ready}, 8'h01, "ready after reset");
    q(rsc_pkg::REG_TIMEOUT_OFS, 8'hff, 8'h3c, "timer default");
    q(rsc_pkg::REG_PROGRESS_OFS, 8'hff, 8'h00, "progress idle");
    q(rsc_pkg::REG_AVAIL_OFS, 8'hff, 8'h01, "available flag");
    q(rsc_pkg::REG_RSSI_OFS, 8'hff, 8'hb0, "signal strength");
    q(8'h01, 8'hff, 8'h00, "unmapped read");
    cmd(rsc_pkg::RSC_CMD_DEREGISTER, 8'h00, 8'h00);
    q(rsc_pkg::REG_FAIL_OFS, 8'hff, 8'hff, "dereg unregistered");
  endtask : t_basics
  task automatic t_enables();
    rsc_pkg::rsc_cmd_t c[4] = '{rsc_pkg::RSC_CMD_CONN_LINKED, rsc_pkg::RSC_CMD_CONN_LINKED_OFF,
      rsc_pkg::RSC_CMD_POWER_ON, rsc_pkg::RSC_CMD_POWER_ON_OFF};
    logic [7:0] e[4] = '{8'h10, 8'h00, 8'h20, 8'h00};
    for (int i = 0; i < 4; i++) begin
      cmd(c[i], 8'h00, 8'h00);
      q(rsc_pkg::REG_NETSTAT_OFS, 8'h30, e[i], "enable bits");
    end
    cmd(rsc_pkg::RSC_CMD_DEREGISTER, 8'h00, 8'h00);
  endtask : t_enables
  // Zero timer: refusals are retried until the network accepts.
  task automatic t_retry();
    int cyc;
    cmd(rsc_pkg::RSC_CMD_SET_TIMEOUT, rsc_pkg::REG_TIMEOUT_OFS, 8'h00);
    q(rsc_pkg::REG_TIMEOUT_OFS, 8'hff, 8'h00, "timer write");
    mode <= 2'd2;
    refuse_code <= 8'h03;
    reg_cnt = 0;
    cmd(rsc_pkg::RSC_CMD_MANUAL_REG, 8'h00, 8'h00);
    for (int i = 0; i < 80 && reg_cnt < 3; i++) @(posedge sys_clk);
    #1;
    chk({7'h0, cmd_ready}, 8'h00, "blocked while registering");
    chk({7'h0, reg_cnt >= 3}, 8'h01, "retries");
    mode <= 2'd0;
    wait_sig(80, 1'b0, cyc);
    q(rsc_pkg::REG_FAIL_OFS, 8'hff, 8'h03, "refusal code");
    q(rsc_pkg::REG_NETSTAT_OFS, 8'h81, 8'h81, "registered in range");
    q(rsc_pkg::REG_PROGRESS_OFS, 8'hff, 8'h05, "progress complete");
  endtask : t_retry
  task automatic t_conn();
    conn_up <= 1'b1;
    q(rsc_pkg::REG_NETSTAT_OFS, 8'h0c, 8'h04, "connected bits");
    phase <= 8'h02;
    cause <= 8'h4e;
    conn_pulse <= 1'b1;
    @(posedge sys_clk);
    conn_pulse <= 1'b0;
    conn_up <= 1'b0;
    q(rsc_pkg::REG_PHASE_OFS, 8'hff, 8'h02, "failure phase");
    q(rsc_pkg::REG_CAUSE_OFS, 8'hff, 8'h4e, "failure cause");
  endtask : t_conn
  // Host keeps the pin low past the minimum, first ignored, then with hang-up.
  task automatic t_escape();
    int cyc = 0;
    int h0;
    cmd(rsc_pkg::RSC_CMD_DIAL, 8'h00, 8'h00);
    chk({6'h0, online_mode, autobaud_enable}, 8'h02, "online, no autobaud");
    chk({6'h0, flow_ctrl_enable, cmd_ready}, 8'h02, "flow on, refused");
    pin <= 1'b0;
    repeat (3 * TRL) @(posedge sys_clk);
    pin <= 1'b1;
    #1;
    chk({7'h0, online_mode}, 8'h01, "pin ignored");
    @(posedge sys_clk);
    tr_mode <= rsc_pkg::RSC_TR_ESCAPE_HANGUP;
    h0 = hang_cnt;
    @(posedge sys_clk);
    pin <= 1'b0;
    while (online_mode !== 1'b0 && cyc < 40) begin
      @(posedge sys_clk);
      #1;
      cyc++;
    end
    chk({7'h0, cyc == TRL + 2}, 8'h01, "escape after low time");
    repeat (2) @(posedge sys_clk);
    pin <= 1'b1;
    #1;
    chk(8'(hang_cnt - h0), 8'h01, "hang-up once");
    tr_mode <= rsc_pkg::RSC_IGNORE_TR;
  endtask : t_escape
  // Stalled network: the manual attempt must end with an error on time.
  task automatic t_timeout();
    int cyc;
    cmd(rsc_pkg::RSC_CMD_DEREGISTER, 8'h00, 8'h00);
    q(rsc_pkg::REG_NETSTAT_OFS, 8'h01, 8'h00, "deregistered");
    cmd(rsc_pkg::RSC_CMD_SET_TIMEOUT, rsc_pkg::REG_TIMEOUT_OFS, 8'h02);
    mode <= 2'd1;
    cmd(rsc_pkg::RSC_CMD_MANUAL_REG, 8'h00, 8'h00);
    wait_sig(4 * SEC, 1'b1, cyc);
    chk({7'h0, cyc >= 2 * SEC && cyc <= 2 * SEC + 2}, 8'h01, "timeout length");
    q(rsc_pkg::REG_FAIL_OFS, 8'hff, 8'hfa, "timeout code");
  endtask : t_timeout
  // Main sequence, and a global limit so no hang goes unreported.
  initial begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_basics();
    t_enables();
    t_retry();
    t_conn();
    t_escape();
    t_timeout();
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    finish_test();
  end
endmodule : testbench
`default_nettype wire
